// File: spi_defs.svh
// Register map, field positions and divider counts for the SPI block
//==============================================================
// Notes on behaviour
// - Interrupt enable gates transfer-complete, mode-fault and overrun onto one request.
// - Output enable resets low, connects the pins, cleared by a master mode fault.
// - Master select drives SCK out; cleared when select goes low in master mode.
// - Clock polarity sets the SCK idle level in master mode; as slave SCK is not driven.
// - Clock phase 0 captures on the first SCK edge, 1 on the second.
// - Divider enable and rate bits pick SCK from /4 to /128; ignored as slave.
// - Transfer-complete sets at byte end; cleared by status access then data access.
// - While transfer-complete is set, data writes are ignored until status is accessed.
// - Data write during a transfer sets the write-collision flag; sequence clears it.
// - Overrun sets when a byte ends with transfer-complete set; status read clears.
// - Mode fault sets on select low as master; status access then control write clears.
// - Output disable stops driving the data output pin.
// - Select management ignores the select pin and uses the internal select bit.
// - Internal select 0 means selected, 1 means deselected.
// - As master, each accepted data write starts one full-duplex byte.
// - Received byte is copied to a read buffer at byte end; reads see the buffer.
// - Data write loads the shift register directly, no holding buffer.
// - Reset clears all control bits and all status bits.
// - While mode fault is set, setting enable and master is refused outside clearing.
// - After overrun the buffer keeps the first byte; later bytes are lost.
// - Write collision only sets its flag, never an interrupt.
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH
// Register indexes; byte address is four times the index
`define IDX_DATA 6'h21
`define IDX_CTRL 6'h22
`define IDX_CSR 6'h23
// Control bits
`define CR_IE 7
`define CR_OE 6
`define CR_DIV 5
`define CR_MASTER_SELECT 4
`define CR_CLOCK_POLARITY 3
`define CR_CLOCK_PHASE 2
// Pin vector positions
`define PIN_SCK 0
`define PIN_MOSI 1
`define PIN_MISO 2
`define PIN_SS 3
// Half SCK period minus one, in clock cycles
`define HALF_DIV4 6'h01
`define HALF_DIV8 6'h03
`define HALF_DIV16 6'h07
`define HALF_DIV32 6'h0F
`define HALF_DIV64 6'h1F
`define HALF_DIV128 6'h3F
`define LAST_EDGE 4'hF
// Extra cycles a master waits before taking the returned bit
`define CAP_LAG 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: spi_master_slave_registers.sv
// SPI master/slave with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "spi_defs.svh"
module spi_master_slave_registers
  import spi_pkg::*;
(
  input wire logic aclk, // System clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, low active
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic sck_in, // Serial clock pin level
  output logic sck_out, // Serial clock drive value
  output logic sck_oe, // Serial clock drive enable
  input wire logic mosi_in, // Master-out pin level
  output logic mosi_out, // Master-out drive value
  output logic mosi_oe, // Master-out drive enable
  input wire logic miso_in, // Master-in pin level
  output logic miso_out, // Master-in drive value
  output logic miso_oe, // Master-in drive enable
  input wire logic ss_n_in, // Slave select pin, low active
  output logic irq // Interrupt request, high active
);
  spi_state_t st;
  spi_state_t nx;
  logic ss_level;
  logic wr_do;
  logic rd_do;
  logic wr_data;
  logic wr_ctrl;
  logic wr_csr;
  logic rd_data;
  logic rd_csr;
  logic sck_tick;
  logic spi_edge;
  logic din;
  logic finish;
  logic [7:0] byte_in;
  logic [7:0] ctrl_val;
  logic [5:0] rd_idx;

  //==============================================================
  // Helpers
  function automatic logic [5:0] half_count(input logic [2:0] rate);
    case (rate)
      3'b100: half_count = `HALF_DIV4;
      3'b000: half_count = `HALF_DIV8;
      3'b001: half_count = `HALF_DIV16;
      3'b110: half_count = `HALF_DIV32;
      3'b010: half_count = `HALF_DIV64;
      default: half_count = `HALF_DIV128;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [7:0] addr, input logic [5:0] idx);
    addr_hit = (addr[7:2] == idx);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = addr_hit(addr, `IDX_DATA) || addr_hit(addr, `IDX_CTRL) ||
             addr_hit(addr, `IDX_CSR);
  endfunction

  //==============================================================
  // Next state
  always_comb begin
    nx = st;
    // Three-stage pin sync; a level counts once stages two and three agree
    nx.pin_s1 = {ss_n_in, miso_in, mosi_in, sck_in};
    nx.pin_s2 = st.pin_s1;
    nx.pin_s3 = st.pin_s2;
    nx.pin_f = (~(st.pin_s2 ^ st.pin_s3) & st.pin_s3) | ((st.pin_s2 ^ st.pin_s3) & st.pin_f);
    ss_level = st.select_management ? st.internal_select : st.pin_f[`PIN_SS];
    din = st.ctrl[`CR_MASTER_SELECT] ? st.pin_f[`PIN_MISO] : st.pin_f[`PIN_MOSI];

    // Bus write channels
    if (awvalid && st.awready) begin
      nx.aw_ok = 1'b1;
      nx.aw_addr = awaddr;
      nx.awready = 1'b0;
    end
    if (wvalid && st.wready) begin
      nx.w_ok = 1'b1;
      nx.w_data = wdata[7:0];
      nx.w_lane0 = wstrb[0];
      nx.wready = 1'b0;
    end
    wr_do = st.aw_ok && st.w_ok && !st.bvalid;
    if (wr_do) begin
      nx.aw_ok = 1'b0;
      nx.w_ok = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = mapped(st.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (st.bvalid && bready) begin
      nx.bvalid = 1'b0;
      nx.awready = 1'b1;
      nx.wready = 1'b1;
    end
    wr_data = wr_do && st.w_lane0 && addr_hit(st.aw_addr, `IDX_DATA);
    wr_ctrl = wr_do && st.w_lane0 && addr_hit(st.aw_addr, `IDX_CTRL);
    wr_csr = wr_do && st.w_lane0 && addr_hit(st.aw_addr, `IDX_CSR);

    // Bus read channels
    rd_do = arvalid && st.arready;
    rd_idx = araddr[7:2];
    rd_data = rd_do && addr_hit(araddr, `IDX_DATA);
    rd_csr = rd_do && addr_hit(araddr, `IDX_CSR);
    if (rd_do) begin
      nx.arready = 1'b0;
      nx.rvalid = 1'b1;
      nx.rresp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (rd_idx)
        `IDX_DATA: nx.rdata = st.rx_buf;
        `IDX_CTRL: nx.rdata = st.ctrl;
        `IDX_CSR: nx.rdata = {st.transfer_complete_flag, st.write_collision_flag, st.overrun_flag, st.mode_fault_flag, 1'b0, st.output_disable, st.select_management,
                              st.internal_select};
        default: nx.rdata = 8'h00;
      endcase
    end
    if (st.rvalid && rready) begin
      nx.rvalid = 1'b0;
      nx.arready = 1'b1;
    end

    // Status register access opens the clearing sequences
    if (rd_csr) begin
      nx.overrun_flag = 1'b0;
    end
    if (rd_csr || wr_csr) begin
      nx.csr_seen = 1'b1;
      if (st.mode_fault_flag) begin
        nx.mode_fault_flag_seen = 1'b1;
      end
    end
    if (wr_csr) begin
      nx.output_disable = st.w_data[2];
      nx.select_management = st.w_data[1];
      nx.internal_select = st.w_data[0];
    end
    ctrl_val = st.w_data;
    if (st.mode_fault_flag && !st.mode_fault_flag_seen) begin
      ctrl_val[`CR_OE] = 1'b0;
      ctrl_val[`CR_MASTER_SELECT] = 1'b0;
    end
    if (wr_ctrl) begin
      nx.ctrl = ctrl_val;
      if (st.mode_fault_flag_seen) begin
        nx.mode_fault_flag = 1'b0;
        nx.mode_fault_flag_seen = 1'b0;
      end
    end
    if ((rd_data || wr_data) && st.csr_seen) begin
      nx.transfer_complete_flag = 1'b0;
      nx.write_collision_flag = 1'b0;
      nx.csr_seen = 1'b0;
    end
    if (wr_data) begin
      if (st.busy || st.fin_pend) begin
        nx.write_collision_flag = 1'b1;
      end else if (!st.transfer_complete_flag || st.csr_seen) begin
        nx.shreg = st.w_data;
        nx.dout = st.w_data[7];
        if (st.ctrl[`CR_MASTER_SELECT]) begin
          nx.busy = 1'b1;
          nx.edge_cnt = 4'h0;
          nx.div_cnt = 6'h00;
        end
      end
    end

    // Edge source: divider as master, synced pin as slave
    sck_tick = 1'b0;
    if (st.busy && st.ctrl[`CR_MASTER_SELECT]) begin
      if (st.div_cnt == half_count({st.ctrl[`CR_DIV], st.ctrl[1:0]})) begin
        nx.div_cnt = 6'h00;
        sck_tick = 1'b1;
        nx.sck_o = ~st.sck_o;
      end else begin
        nx.div_cnt = st.div_cnt + 6'h01;
      end
    end
    spi_edge = sck_tick || (!st.ctrl[`CR_MASTER_SELECT] && st.ctrl[`CR_OE] && !ss_level &&
                (nx.pin_f[`PIN_SCK] != st.pin_f[`PIN_SCK]));
    byte_in = st.shreg;
    finish = 1'b0;
    // Master takes the returned bit late, covering the pin sync delay
    if (st.cap_pend) begin
      if (st.cap_wait == 2'h0) begin
        nx.cap_pend = 1'b0;
        nx.rx_sh = {st.rx_sh[6:0], din};
        if (st.fin_pend) begin
          nx.fin_pend = 1'b0;
          finish = 1'b1;
        end
      end else begin
        nx.cap_wait = st.cap_wait - 2'h1;
      end
    end
    if (spi_edge) begin
      nx.busy = 1'b1;
      nx.edge_cnt = st.edge_cnt + 4'h1;
      if (st.edge_cnt[0] == st.ctrl[`CR_CLOCK_PHASE]) begin
        byte_in = {st.shreg[6:0], din};
        nx.shreg = byte_in;
        if (st.ctrl[`CR_MASTER_SELECT]) begin
          nx.cap_pend = 1'b1;
          nx.cap_wait = `CAP_LAG;
        end else begin
          nx.rx_sh = {st.rx_sh[6:0], din};
        end
      end else begin
        nx.dout = st.shreg[7];
      end
      if (st.edge_cnt == `LAST_EDGE) begin
        nx.busy = 1'b0;
        nx.edge_cnt = 4'h0;
        if (nx.cap_pend) begin
          nx.fin_pend = 1'b1;
        end else begin
          finish = 1'b1;
        end
      end
    end
    // Byte end: load the buffer or flag an overrun
    if (finish) begin
      if (nx.transfer_complete_flag) begin
        nx.overrun_flag = 1'b1;
      end else begin
        nx.rx_buf = nx.rx_sh;
      end
      nx.transfer_complete_flag = 1'b1;
    end
    // Slave deselected mid-byte drops the partial byte
    if (!st.ctrl[`CR_MASTER_SELECT] && ss_level) begin
      nx.busy = 1'b0;
      nx.edge_cnt = 4'h0;
    end
    if (st.ctrl[`CR_MASTER_SELECT] && !ss_level) begin
      nx.mode_fault_flag = 1'b1;
      nx.ctrl[`CR_OE] = 1'b0;
      nx.ctrl[`CR_MASTER_SELECT] = 1'b0;
      nx.cap_pend = 1'b0;
      nx.fin_pend = 1'b0;
      nx.busy = 1'b0;
      nx.edge_cnt = 4'h0;
      nx.div_cnt = 6'h00;
    end
    if (!nx.busy) begin
      nx.sck_o = nx.ctrl[`CR_CLOCK_POLARITY];
    end
    nx.sck_oe = nx.ctrl[`CR_OE] && nx.ctrl[`CR_MASTER_SELECT];
    nx.mosi_oe = nx.ctrl[`CR_OE] && nx.ctrl[`CR_MASTER_SELECT] && !nx.output_disable;
    nx.miso_oe = nx.ctrl[`CR_OE] && !nx.ctrl[`CR_MASTER_SELECT] && !nx.output_disable && !ss_level;
    nx.irq = nx.ctrl[`CR_IE] && (nx.transfer_complete_flag || nx.mode_fault_flag || nx.overrun_flag);
  end

  //==============================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.pin_s1 <= 4'hF;
      st.pin_s2 <= 4'hF;
      st.pin_s3 <= 4'hF;
      st.pin_f <= 4'hF;
    end else begin
      st <= nx;
    end
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = {24'h000000, st.rdata};
  assign sck_out = st.sck_o;
  assign sck_oe = st.sck_oe;
  assign mosi_out = st.dout;
  assign mosi_oe = st.mosi_oe;
  assign miso_out = st.dout;
  assign miso_oe = st.miso_oe;
  assign irq = st.irq;

  //==============================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_sck_toggle;
    $changed(st.sck_o);
  endsequence

  sequence s_half_div4;
    !$changed(st.sck_o) ##1 ($changed(st.sck_o) || !st.busy);
  endsequence

  property p_irq_on_flag;
    $rose(st.transfer_complete_flag) && st.ctrl[`CR_IE] |-> irq;
  endproperty
  a_irq_on_flag: assert property (p_irq_on_flag) else $error("irq missing");

  property p_fault;
    st.ctrl[`CR_MASTER_SELECT] && !ss_level |=> st.mode_fault_flag && !st.ctrl[`CR_MASTER_SELECT] && !st.ctrl[`CR_OE];
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not taken");

  property p_write_collision_flag_quiet;
    st.write_collision_flag && !st.transfer_complete_flag && !st.mode_fault_flag && !st.overrun_flag |-> !irq;
  endproperty
  a_write_collision_flag_quiet: assert property (p_write_collision_flag_quiet) else $error("collision raised irq");

  property p_sck_idle;
    !st.busy && $stable(st.ctrl[`CR_CLOCK_POLARITY]) |-> sck_out == st.ctrl[`CR_CLOCK_POLARITY];
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck idle level wrong");

  property p_done_flag;
    $fell(st.busy) && st.ctrl[`CR_MASTER_SELECT] |-> st.transfer_complete_flag || st.fin_pend;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("transfer flag not set");

  property p_start;
    wr_data && st.ctrl[`CR_MASTER_SELECT] && ss_level && !st.busy && !st.transfer_complete_flag |=> st.busy;
  endproperty
  a_start: assert property (p_start) else $error("master write did not start");

  property p_collision;
    wr_data && st.busy && !spi_edge |=> st.write_collision_flag && $stable(st.shreg);
  endproperty
  a_collision: assert property (p_collision) else $error("collision mishandled");

  property p_ovr_keep;
    $rose(st.overrun_flag) |-> $stable(st.rx_buf);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("buffer overwritten");

  property p_div4;
    s_sck_toggle and st.busy && {st.ctrl[`CR_DIV], st.ctrl[1:0]} == 3'b100 |=> s_half_div4;
  endproperty
  a_div4: assert property (p_div4) else $error("sck rate wrong");

  property p_sod;
    st.output_disable |-> !mosi_oe && !miso_oe;
  endproperty
  a_sod: assert property (p_sod) else $error("output not disabled");

  property p_late_done;
    st.fin_pend && st.cap_pend && st.cap_wait == 2'h0 |=> st.transfer_complete_flag;
  endproperty
  a_late_done: assert property (p_late_done) else $error("late byte end lost");

  property p_ovr_irq;
    $rose(st.overrun_flag) && st.ctrl[`CR_IE] |-> irq;
  endproperty
  a_ovr_irq: assert property (p_ovr_irq) else $error("overrun irq missing");

  property p_flag_lock;
    wr_data && st.transfer_complete_flag && !st.csr_seen && !spi_edge |=> $stable(st.shreg);
  endproperty
  a_flag_lock: assert property (p_flag_lock) else $error("locked write taken");

  property p_pins_off;
    !st.ctrl[`CR_OE] |-> !sck_oe && !mosi_oe && !miso_oe;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins driven while off");
endmodule

// File: spi_master_slave_registers_bench.sv
// Self-checking bench for the SPI block
`timescale 1ns/10ps
`include "spi_defs.svh"
module spi_master_slave_registers_bench;
  import spi_pkg::*;
  localparam logic [7:0] A_DATA = {`IDX_DATA, 2'h0};
  localparam logic [7:0] A_CTRL = {`IDX_CTRL, 2'h0};
  localparam logic [7:0] A_CSR = {`IDX_CSR, 2'h0};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, s_tx = 8'h00, s_rx;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, ss_n_in = 1'h1;
  logic bready = 1'h1, rready = 1'h1, s_sel_n = 1'h1, s_clock_phase = 1'h0, prev_sck = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, s_miso;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic [1:0] bresp, rresp, resp;
  int gap = 0, half = 0, edges = 0, cyc = 0, num_errors = 0, num_checks = 0;
  logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  // Pull-down on the clock line, pull-up on the master-out line
  wire sck_w = sck_oe ? sck_out : 1'h0;
  wire mosi_w = mosi_oe ? mosi_out : 1'h1;
  wire miso_w = miso_oe ? miso_out : s_miso;

  spi_master_slave_registers uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in), .irq(irq));
  spi_slave_model peer (.sck(sck_w), .mosi(mosi_w), .sel_n(s_sel_n), .clock_phase(s_clock_phase),
    .tx(s_tx), .miso(s_miso), .rx(s_rx));

  initial begin
    forever #50 aclk = ~aclk;
  end
  //==============================================================
  // Clock edge counter, half period and hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_sck <= sck_out;
    gap <= gap + 1;
    if (sck_oe === 1'h1 && sck_out !== prev_sck) begin
      half <= gap;
      gap <= 1;
      edges <= edges + 1;
    end
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  //==============================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (aw && awready === 1'h1) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready === 1'h1) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
    end while (bvalid !== 1'h1);
    resp = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    resp = rresp;
  endtask
  task automatic wait_irq;
    do @(posedge aclk); while (irq !== 1'h1);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  //==============================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] r;
    chk("pins and irq", 4'h0, {sck_oe, mosi_oe, miso_oe, irq});
    axi_rd(A_CTRL, r);
    chk("control reset", 8'h00, r);
    axi_rd(A_CSR, r);
    chk("status reset", 8'h00, r);
    axi_rd(8'h90, r);
    chk("unmapped read", `RESP_SLVERR, resp);
    axi_wr(8'h90, 8'hFF);
    chk("unmapped write", `RESP_SLVERR, resp);
  endtask
  task automatic t_xfer(input int i);
    logic [31:0] r;
    logic [7:0] tx, stx;
    int e0;
    tx = 8'hC3 ^ 8'(i);
    stx = 8'h5A + 8'(i);
    axi_wr(A_CTRL, 8'h00);
    s_clock_phase <= i[0];
    s_tx <= stx;
    axi_wr(A_CTRL, {2'h3, codes[i][2], 1'h1, i[1], i[0], codes[i][1:0]});
    s_sel_n <= 1'h0;
    @(posedge aclk);
    e0 = edges;
    axi_wr(A_DATA, tx);
    wait_irq();
    repeat (2) @(posedge aclk);
    s_sel_n <= 1'h1;
    chk("sck edges", 16, edges - e0);
    chk("sck half period", 2 << i, half);
    chk("sck idle", i[1], sck_out);
    chk("slave received", tx, s_rx);
    axi_rd(A_CSR, r);
    chk("done status", 8'h80, r);
    axi_rd(A_DATA, r);
    chk("read buffer", stx, r);
    axi_rd(A_CSR, r);
    chk("status cleared", 8'h00, r);
  endtask
  task automatic t_collide;
    logic [31:0] r;
    int e0;
    s_clock_phase <= 1'h1;
    s_tx <= 8'h96;
    axi_wr(A_CTRL, 8'h00);
    axi_wr(A_CTRL, 8'hDF);
    s_sel_n <= 1'h0;
    axi_wr(A_DATA, 8'h69);
    axi_wr(A_DATA, 8'hFF);
    chk("irq on collision", 1'h0, irq);
    wait_irq();
    repeat (2) @(posedge aclk);
    s_sel_n <= 1'h1;
    chk("transfer kept", 8'h69, s_rx);
    e0 = edges;
    axi_wr(A_DATA, 8'h00);
    repeat (40) @(posedge aclk);
    chk("ignored write", 0, edges - e0);
    axi_rd(A_CSR, r);
    chk("collision status", 8'hC0, r);
    axi_rd(A_DATA, r);
    chk("buffer kept", 8'h96, r);
    axi_rd(A_CSR, r);
    chk("flags cleared", 8'h00, r);
    chk("irq cleared", 1'h0, irq);
  endtask
  task automatic t_fault;
    logic [31:0] r;
    axi_wr(A_CTRL, 8'h00);
    axi_wr(A_CTRL, 8'hD0);
    ss_n_in <= 1'h0;
    repeat (8) @(posedge aclk);
    chk("fault irq", 1'h1, irq);
    axi_rd(A_CTRL, r);
    chk("fault drops enables", 8'h80, r);
    axi_wr(A_CTRL, 8'hD0);
    axi_rd(A_CTRL, r);
    chk("enables refused", 8'h80, r);
    ss_n_in <= 1'h1;
    repeat (6) @(posedge aclk);
    axi_rd(A_CSR, r);
    chk("fault flag", 8'h10, r);
    axi_wr(A_CTRL, 8'h50);
    axi_rd(A_CSR, r);
    chk("fault cleared", 8'h00, r);
    chk("master clock drive", 1'h1, sck_oe);
  endtask
  task automatic t_manage;
    logic [31:0] r;
    chk("data out driven", 1'h1, mosi_oe);
    axi_wr(A_CSR, 8'h07);
    ss_n_in <= 1'h0;
    repeat (8) @(posedge aclk);
    axi_rd(A_CSR, r);
    chk("pin select ignored", 8'h07, r);
    chk("data out disabled", 1'h0, mosi_oe);
    axi_wr(A_CSR, 8'h06);
    repeat (4) @(posedge aclk);
    axi_rd(A_CSR, r);
    chk("internal select fault", 8'h16, r);
  endtask
  //==============================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    for (int i = 0; i < 6; i++) begin
      t_xfer(i);
    end
    t_collide();
    t_fault();
    t_manage();
    tally_and_finish();
  end
endmodule

// File: spi_pkg.sv
// Types shared by the SPI block
package spi_pkg;
  typedef struct packed {
    logic [7:0] ctrl;
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic output_disable;
    logic select_management;
    logic internal_select;
    logic csr_seen;
    logic mode_fault_flag_seen;
    logic [7:0] shreg;
    logic [7:0] rx_buf;
    logic [7:0] rx_sh;
    logic [1:0] cap_wait;
    logic cap_pend;
    logic fin_pend;
    logic dout;
    logic busy;
    logic [3:0] edge_cnt;
    logic [5:0] div_cnt;
    logic sck_o;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_f;
    logic aw_ok;
    logic w_ok;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic sck_oe;
    logic mosi_oe;
    logic miso_oe;
    logic irq;
  } spi_state_t;
endpackage

// File: spi_slave_model.sv
// Behavioural SPI slave standing on the far side of the master
`timescale 1ns/10ps
module spi_slave_model (
  input wire logic sck, // Serial clock line
  input wire logic mosi, // Data from the master
  input wire logic sel_n, // Select, low active
  input wire logic clock_phase, // Phase, set equal to the master's
  input wire logic [7:0] tx, // Byte to return
  output logic miso, // Data to the master
  output logic [7:0] rx // Byte received
);
  logic [7:0] sh;
  int cnt;
  initial begin
    miso = 1'h1;
    rx = 8'h00;
  end
  //==============================================================
  // Frame start: phase 0 shows the first bit at select
  always @(negedge sel_n) begin
    sh = tx;
    cnt = 0;
    if (!clock_phase) begin
      miso = sh[7];
    end
  end
  // Released line shows the inverse of its last level
  always @(posedge sel_n) begin
    miso = ~miso;
  end
  //==============================================================
  // Capture and shift edges alternate, eight bits MSB first
  always @(sck) begin
    if (sel_n === 1'h0) begin
      cnt++;
      if (cnt[0] ^ clock_phase) begin
        rx = {rx[6:0], mosi};
      end else if (clock_phase) begin
        miso = sh[7];
        sh = sh << 1;
      end else begin
        sh = sh << 1;
        miso = sh[7];
      end
    end
  end
endmodule
